/* hw/pste_pkg.sv */
// constants and types for the pwm channel with start delay, trigger and emergency stop
package pste_pkg;

  // ****************************************************************
  // register word indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [15:0] PSTE_IDX_CNT_LO   = 16'hF910;
  localparam logic [15:0] PSTE_IDX_CNT_HI   = 16'hF911;
  localparam logic [15:0] PSTE_IDX_DUTY_LO  = 16'hF912;
  localparam logic [15:0] PSTE_IDX_DUTY_HI  = 16'hF913;
  localparam logic [15:0] PSTE_IDX_PER_LO   = 16'hF914;
  localparam logic [15:0] PSTE_IDX_PER_HI   = 16'hF915;
  localparam logic [15:0] PSTE_IDX_RUN_CTL  = 16'hF917;
  localparam logic [15:0] PSTE_IDX_TRIG_MD  = 16'hF918;
  localparam logic [15:0] PSTE_IDX_TES      = 16'hF919;
  localparam logic [15:0] PSTE_IDX_WAIT     = 16'hF91A;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned PSTE_RC_RUN   = 0;
  localparam int unsigned PSTE_RC_TGEN  = 1;
  localparam int unsigned PSTE_RC_ESTOP = 5;
  localparam int unsigned PSTE_TM_START = 0;
  localparam int unsigned PSTE_TM_STOP  = 1;
  localparam int unsigned PSTE_TM_CLR   = 2;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] PSTE_ES_OFF  = 2'h0;
  localparam logic [1:0] PSTE_ES_COMPARATOR_ZERO_OUT = 2'h1;
  localparam logic [1:0] PSTE_ES_COMPARATOR_ONE_OUT = 2'h2;
  localparam logic [1:0] PSTE_ES_PB0  = 2'h3;
  localparam logic [2:0] PSTE_SRC_PA_MAX = 3'h2;
  localparam logic [2:0] PSTE_SRC_PROH_A = 3'h3;
  localparam logic [2:0] PSTE_SRC_PROH_B = 3'h4;
  localparam logic [2:0] PSTE_SRC_TMR_A  = 3'h5;
  localparam logic [2:0] PSTE_SRC_TMR_B  = 3'h6;
  localparam logic [2:0] PSTE_SRC_TMR_C  = 3'h7;
  localparam logic [2:0] PSTE_SRC_PB0    = 3'h0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  PSTE_TES_RST  = 8'h00;
  localparam logic [7:0]  PSTE_WAIT_RST = 8'h00;
  localparam logic [2:0]  PSTE_TM_RST   = 3'h0;
  localparam logic [15:0] PSTE_CNT_ZERO = 16'h0000;
  localparam logic [15:0] PSTE_DUTY_RST = 16'h0000;
  localparam logic [15:0] PSTE_PER_RST  = 16'hFFFF;
  localparam logic [7:0]  PSTE_WAIT_NONE = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] estop_sel;
    logic       trigger_bank_sel;
    logic [2:0] src;
  } pste_tes_t;

  typedef enum logic [1:0] {PSTE_IDLE, PSTE_DELAY, PSTE_RUN} pste_state_t;

endpackage

/* hw/pste_top.sv */
// pwm counter channel with start delay, external trigger and emergency stop
// Functional notes
// - bank and code select pin or timer
// - bank 0 codes 3,4 give no trigger
// - timer trigger uses raw request, not enable
// - estop select: off, comparator_zero_out, comparator_one_out, port b0
// - same pin for trigger and estop blocks channel
// - run starts 8-bit wait counter first
// - wait value zero skips the delay
// - delay pending: ignore ext stop, keep estop
// - status on first tick, count from second
// - duty match clears output on next tick
// - period match: set output, wrap, reload buffers
// - one more tick counts after run cleared
// - restart resumes from retained count
// - counter write clears count, sets output
// - stopped: duty/period writes reach buffers directly
// - period is setting+1, duty setting+1 ticks
// - ignore ext stop/start until status follows
// - ext control needs source, mode, enable bit
// - trigger sampled per tick, short pulses rejected
// - estop edge: flag, irq, stop, clear, output off
// - write one clears estop flag
// - estop flag at run control bit 5
`timescale 1ns/10ps
module pste_top (
  // clock, reset, freeze
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // selected pwm clock, one pulse per falling edge
  input  wire logic        count_tick_i,
  // trigger and estop sources
  input  wire logic [2:0]  port_a_pin_i,
  input  wire logic [7:0]  port_b_pin_i,
  input  wire logic        timer_a_irq_req_i,
  input  wire logic        timer_b_irq_req_i,
  input  wire logic        timer_c_irq_req_i,
  input  wire logic        comparator_zero_out_i,
  input  wire logic        comparator_one_out_i,
  // pwm results
  output logic             pwm_out_o,
  output logic             pwm_irq_o
);
  import pste_pkg::*;

  function automatic logic rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  pste_state_t state_reg;
  pste_tes_t   tes_reg;
  logic [7:0]  wait_reg;
  logic [7:0]  wait_cnt_reg;
  logic [2:0]  tmode_reg;
  logic        run_reg;
  logic        tgen_reg;
  logic        estop_reg;
  logic        flag_reg;
  logic [15:0] cnt_reg;
  logic [15:0] duty_reg;
  logic [15:0] per_reg;
  logic [15:0] dbuf_reg;
  logic [15:0] pbuf_reg;
  logic        samp_reg;
  logic        filt_reg;
  logic        es_prev_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        irq_reg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire        wb_hit   = ce_i & wb_cyc_i & wb_stb_i;
  wire        wr_fire  = wb_hit & ack_reg & wb_we_i & wb_sel_i[0];
  wire [15:0] idx      = wb_adr_i[17:2];
  wire [7:0]  wbyte    = wb_dat_i[7:0];
  wire        wr_cnt   = wr_fire & (idx == PSTE_IDX_CNT_LO | idx == PSTE_IDX_CNT_HI);
  wire        wr_dlo   = wr_fire & (idx == PSTE_IDX_DUTY_LO);
  wire        wr_dhi   = wr_fire & (idx == PSTE_IDX_DUTY_HI);
  wire        wr_plo   = wr_fire & (idx == PSTE_IDX_PER_LO);
  wire        wr_phi   = wr_fire & (idx == PSTE_IDX_PER_HI);
  wire        wr_rc    = wr_fire & (idx == PSTE_IDX_RUN_CTL);
  wire        wr_tm    = wr_fire & (idx == PSTE_IDX_TRIG_MD);
  wire        wr_tes   = wr_fire & (idx == PSTE_IDX_TES);
  wire        wr_wait  = wr_fire & (idx == PSTE_IDX_WAIT);
  wire [15:0] duty_nx  = wr_dlo ? {duty_reg[15:8], wbyte} :
                         wr_dhi ? {wbyte, duty_reg[7:0]} : duty_reg;
  wire [15:0] per_nx   = wr_plo ? {per_reg[15:8], wbyte} :
                         wr_phi ? {wbyte, per_reg[7:0]} : per_reg;
  wire        active   = (state_reg == PSTE_RUN);
  wire [7:0]  rc_byte  = {active, flag_reg, estop_reg, 3'h0, tgen_reg, run_reg};
  wire [7:0]  rd_byte  =
    (idx == PSTE_IDX_CNT_LO)  ? cnt_reg[7:0]   :
    (idx == PSTE_IDX_CNT_HI)  ? cnt_reg[15:8]  :
    (idx == PSTE_IDX_DUTY_LO) ? duty_reg[7:0]  :
    (idx == PSTE_IDX_DUTY_HI) ? duty_reg[15:8] :
    (idx == PSTE_IDX_PER_LO)  ? per_reg[7:0]   :
    (idx == PSTE_IDX_PER_HI)  ? per_reg[15:8]  :
    (idx == PSTE_IDX_RUN_CTL) ? rc_byte        :
    (idx == PSTE_IDX_TRIG_MD) ? {5'h00, tmode_reg} :
    (idx == PSTE_IDX_TES)     ? tes_reg        :
    (idx == PSTE_IDX_WAIT)    ? wait_reg       : 8'h00;

  // ****************************************************************
  // source selection
  // ****************************************************************
  wire [2:0] src  = tes_reg.src;
  wire       bank = tes_reg.trigger_bank_sel;
  // timer requests are taken raw, ahead of any interrupt enable
  wire       tmr_src = (src == PSTE_SRC_TMR_A) ? timer_a_irq_req_i :
                       (src == PSTE_SRC_TMR_B) ? timer_b_irq_req_i :
                       (src == PSTE_SRC_TMR_C) ? timer_c_irq_req_i : 1'b0;
  // codes 3 and 4 of bank 0 fall through to a constant low
  wire       trig_src = bank ? port_b_pin_i[src] :
                        (src <= PSTE_SRC_PA_MAX) ? port_a_pin_i[src[1:0]] : tmr_src;
  wire       es_src = (tes_reg.estop_sel == PSTE_ES_COMPARATOR_ZERO_OUT) ? comparator_zero_out_i :
                      (tes_reg.estop_sel == PSTE_ES_COMPARATOR_ONE_OUT) ? comparator_one_out_i  :
                      (tes_reg.estop_sel == PSTE_ES_PB0)  ? port_b_pin_i[0]      : 1'b0;
  // one pin serving both roles leaves the channel dead
  wire       blocked = (tes_reg.estop_sel == PSTE_ES_PB0) & bank & (src == PSTE_SRC_PB0);
  wire       tick    = ce_i & count_tick_i & ~blocked;

  // ****************************************************************
  // trigger filter and events
  // ****************************************************************
  // a level must be seen on two ticks running before it counts
  wire filt_nx   = (trig_src == samp_reg) ? samp_reg : filt_reg;
  wire trig_edge = tick & rise(filt_reg, filt_nx);
  wire ext_ok    = tgen_reg & (tmode_reg[1:0] != 2'h0);
  wire ext_start = trig_edge & ext_ok & tmode_reg[PSTE_TM_START] & ~run_reg
                   & (state_reg == PSTE_IDLE);
  wire ext_stop  = trig_edge & ext_ok & tmode_reg[PSTE_TM_STOP] & run_reg
                   & active;
  wire estop_hit = ce_i & ~blocked & rise(es_prev_reg, es_src);

  // ****************************************************************
  // counter step
  // ****************************************************************
  wire        step    = tick & active;
  wire        at_per  = (cnt_reg == pbuf_reg);
  wire        at_duty = (cnt_reg == dbuf_reg);
  wire [15:0] cnt_inc = cnt_reg + 16'h0001;
  wire        clr_ext = ext_stop & tmode_reg[PSTE_TM_CLR];
  wire [15:0] cnt_nx  = (estop_hit | wr_cnt | clr_ext) ? PSTE_CNT_ZERO :
                        ~step  ? cnt_reg :
                        at_per ? PSTE_CNT_ZERO : cnt_inc;
  wire        flag_nx = estop_hit ? 1'b0 :
                        wr_cnt    ? 1'b1 :
                        (step & at_per)  ? 1'b1 :
                        (step & at_duty) ? 1'b0 : flag_reg;
  wire        run_nx  = estop_hit ? 1'b0 :
                        wr_rc     ? wbyte[PSTE_RC_RUN] :
                        ext_start ? 1'b1 :
                        ext_stop  ? 1'b0 : run_reg;
  wire        wait_done = (wait_reg == PSTE_WAIT_NONE);
  wire [7:0]  wait_inc  = wait_cnt_reg + 8'h01;

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= wb_hit & ~ack_reg;
      if (wb_hit & ~ack_reg) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tes_reg   <= PSTE_TES_RST;
      wait_reg  <= PSTE_WAIT_RST;
      tmode_reg <= PSTE_TM_RST;
      tgen_reg  <= 1'b0;
      duty_reg  <= PSTE_DUTY_RST;
      per_reg   <= PSTE_PER_RST;
    end else if (ce_i) begin
      duty_reg <= duty_nx;
      per_reg  <= per_nx;
      if (wr_tes) begin
        tes_reg <= {2'h0, wbyte[5:0]};
      end
      if (wr_wait) begin
        wait_reg <= wbyte;
      end
      if (wr_tm) begin
        tmode_reg <= wbyte[2:0];
      end
      if (wr_rc) begin
        tgen_reg <= wbyte[PSTE_RC_TGEN];
      end
    end
  end

  // ****************************************************************
  // run control and estop flag
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg     <= 1'b0;
      estop_reg   <= 1'b0;
      es_prev_reg <= 1'b0;
      samp_reg    <= 1'b0;
      filt_reg    <= 1'b0;
      irq_reg     <= 1'b0;
    end else if (ce_i) begin
      run_reg     <= run_nx;
      es_prev_reg <= es_src;
      // a new edge outranks a clearing write in the same cycle
      estop_reg   <= estop_hit | (estop_reg & ~(wr_rc & wbyte[PSTE_RC_ESTOP]));
      irq_reg     <= estop_hit | ext_stop | (step & (at_per | at_duty));
      if (tick) begin
        samp_reg <= trig_src;
        filt_reg <= filt_nx;
      end
    end
  end

  // ****************************************************************
  // sequencer and counter
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= PSTE_IDLE;
      wait_cnt_reg <= 8'h00;
      cnt_reg      <= PSTE_CNT_ZERO;
      flag_reg     <= 1'b1;
      dbuf_reg     <= PSTE_DUTY_RST;
      pbuf_reg     <= PSTE_PER_RST;
    end else if (ce_i) begin
      cnt_reg  <= cnt_nx;
      flag_reg <= flag_nx;
      if ((step & at_per) | ~run_reg) begin
        dbuf_reg <= duty_nx;
        pbuf_reg <= per_nx;
      end
      if (estop_hit) begin
        state_reg <= PSTE_IDLE;
      end else if (tick) begin
        unique case (state_reg)
          PSTE_IDLE: begin
            wait_cnt_reg <= 8'h00;
            if (run_reg) begin
              state_reg <= wait_done ? PSTE_RUN : PSTE_DELAY;
            end
          end
          PSTE_DELAY: begin
            wait_cnt_reg <= wait_inc;
            if (~run_reg) begin
              state_reg <= PSTE_IDLE;
            end else if (wait_inc == wait_reg) begin
              state_reg <= PSTE_RUN;
            end
          end
          PSTE_RUN: begin
            if (~run_reg) begin
              state_reg <= PSTE_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = dat_reg;
  assign pwm_out_o = flag_reg;
  assign pwm_irq_o = irq_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_estop;
    @(posedge clk_i) disable iff (rst_i)
    estop_hit |=> estop_reg && !flag_reg && !active && cnt_reg == PSTE_CNT_ZERO && pwm_irq_o;
  endproperty
  a_estop: assert property (p_estop) else $error("estop did not stop");

  property p_cnt_wr;
    @(posedge clk_i) disable iff (rst_i)
    wr_cnt && !estop_hit |=> cnt_reg == PSTE_CNT_ZERO && flag_reg;
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("counter write no clear");

  property p_period;
    @(posedge clk_i) disable iff (rst_i)
    step && at_per && !estop_hit && !wr_cnt && !clr_ext
    |=> cnt_reg == PSTE_CNT_ZERO && flag_reg && pbuf_reg == $past(per_nx);
  endproperty
  a_period: assert property (p_period) else $error("period match wrong");

  property p_duty;
    @(posedge clk_i) disable iff (rst_i)
    step && at_duty && !at_per && !estop_hit && !wr_cnt |=> !pwm_out_o;
  endproperty
  a_duty: assert property (p_duty) else $error("duty match wrong");

  property p_prohibited;
    @(posedge clk_i) disable iff (rst_i)
    !bank && (src == PSTE_SRC_PROH_A || src == PSTE_SRC_PROH_B) |-> !trig_src && !trig_edge;
  endproperty
  a_prohibited: assert property (p_prohibited) else $error("prohibited code drives");

  property p_nowait;
    @(posedge clk_i) disable iff (rst_i)
    tick && run_reg && state_reg == PSTE_IDLE && wait_done && !estop_hit
    |=> active && cnt_reg == $past(cnt_reg);
  endproperty
  a_nowait: assert property (p_nowait) else $error("direct start wrong");

  property p_tail;
    @(posedge clk_i) disable iff (rst_i)
    step && !run_reg |=> !active && (cnt_reg != $past(cnt_reg) || $past(at_per));
  endproperty
  a_tail: assert property (p_tail) else $error("final count missing");

  property p_w1c;
    @(posedge clk_i) disable iff (rst_i)
    wr_rc && !estop_hit |=> estop_reg == ($past(estop_reg) && !$past(wbyte[PSTE_RC_ESTOP]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("estop flag clear wrong");

  property p_start_ignored;
    @(posedge clk_i) disable iff (rst_i)
    state_reg != PSTE_IDLE && !run_reg && !wr_rc |=> !run_reg;
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start taken while stopping");

  property p_delay_stop;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == PSTE_DELAY && run_reg && !estop_hit && !wr_rc |=> run_reg;
  endproperty
  a_delay_stop: assert property (p_delay_stop) else $error("stop taken in delay");

  property p_blocked;
    @(posedge clk_i) disable iff (rst_i)
    blocked && state_reg == PSTE_IDLE |=> (state_reg == PSTE_IDLE) [*2];
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked channel ran");

  property p_rsv;
    @(posedge clk_i) disable iff (rst_i)
    wr_tes |=> tes_reg.rsv == 2'h0 && tes_reg[5:0] == $past(wbyte[5:0]);
  endproperty
  a_rsv: assert property (p_rsv) else $error("selection write wrong");

endmodule

/* bench/pwm_start_trigger_estop_bench.sv */
// self-checking bench for the pwm channel with start delay, trigger and emergency stop
`timescale 1ns/10ps
module pwm_start_trigger_estop_bench;
  import pste_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [17:0] wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        cnt_tick;
  logic [2:0]  port_a;
  logic [7:0]  port_b;
  logic        comparator_zero_out;
  logic        comparator_one_out;
  logic [2:0]  tmr;
  logic        pwm_out_o;
  logic        pwm_irq_o;
  int          error_cnt;
  int          n_tests;
  int          irq_cnt = 0;
  int          cyc_cnt = 0;

  pste_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .count_tick_i(cnt_tick), .port_a_pin_i(port_a), .port_b_pin_i(port_b),
    .timer_a_irq_req_i(tmr[0]), .timer_b_irq_req_i(tmr[1]), .timer_c_irq_req_i(tmr[2]),
    .comparator_zero_out_i(comparator_zero_out), .comparator_one_out_i(comparator_one_out),
    .pwm_out_o(pwm_out_o), .pwm_irq_o(pwm_irq_o)
  );

  // ****************************************************************
  // clock, monitors, timeout
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (pwm_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      give_verdict;
    end
  end

  // ****************************************************************
  // bus and tick helpers
  // ****************************************************************
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    {wb_cyc, wb_stb, wb_we} <= {2'b11, w};
    wb_adr <= {idx, 2'b00};
    wb_dat <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // masked read compare, so don't-care bits can be left out
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(nm, e, q & m);
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      cnt_tick <= 1'b1;
      @(posedge clk_i);
      cnt_tick <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic chk_out(input logic e);
    chk("pwm_out", {7'h0, e}, {7'h0, pwm_out_o});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    rdc("tes", PSTE_IDX_TES, 8'hFF, PSTE_TES_RST);
    rdc("wait", PSTE_IDX_WAIT, 8'hFF, PSTE_WAIT_RST);
    rdc("run_ctl", PSTE_IDX_RUN_CTL, 8'hFF, 8'h40);
    wr(PSTE_IDX_TES, 8'hFF);
    rdc("tes_rsv", PSTE_IDX_TES, 8'hFF, 8'h3F);
    rdc("unmapped", 16'hF916, 8'hFF, 8'h00);
    wr(PSTE_IDX_TES, 8'h00);
  endtask

  task automatic t_walk;
    logic [9:0] exp_o;
    exp_o = 10'b1100110010;
    wr(PSTE_IDX_DUTY_LO, 8'h01);
    wr(PSTE_IDX_DUTY_HI, 8'h00);
    wr(PSTE_IDX_PER_LO, 8'h03);
    wr(PSTE_IDX_PER_HI, 8'h00);
    wr(PSTE_IDX_CNT_LO, 8'h00);
    wr(PSTE_IDX_RUN_CTL, 8'h01);
    for (int i = 0; i < 10; i++) begin
      // new duty only reaches the compare after the next period match
      if (i == 7) wr(PSTE_IDX_DUTY_LO, 8'h00);
      tick(1);
      chk_out(exp_o[9 - i]);
    end
    // stop: one more count step, status falls on the same tick
    wr(PSTE_IDX_RUN_CTL, 8'h00);
    tick(3);
    rdc("cnt_stop", PSTE_IDX_CNT_LO, 8'hFF, 8'h02);
    rdc("stopped", PSTE_IDX_RUN_CTL, 8'h81, 8'h00);
    wr(PSTE_IDX_RUN_CTL, 8'h01);
    tick(2);
    rdc("cnt_resume", PSTE_IDX_CNT_LO, 8'hFF, 8'h03);
    rdc("running", PSTE_IDX_RUN_CTL, 8'h81, 8'h81);
    wr(PSTE_IDX_CNT_HI, 8'h55);
    rdc("cnt_clr", PSTE_IDX_CNT_LO, 8'hFF, 8'h00);
    chk_out(1'b1);
    wr(PSTE_IDX_RUN_CTL, 8'h00);
    tick(2);
  endtask

  task automatic t_delay;
    wr(PSTE_IDX_WAIT, 8'h02);
    wr(PSTE_IDX_RUN_CTL, 8'h01);
    tick(2);
    rdc("delay_pend", PSTE_IDX_RUN_CTL, 8'h81, 8'h01);
    tick(1);
    rdc("delay_done", PSTE_IDX_RUN_CTL, 8'h81, 8'h81);
    wr(PSTE_IDX_RUN_CTL, 8'h00);
    tick(2);
    wr(PSTE_IDX_WAIT, 8'h00);
    // same pin for trigger and emergency stop: channel must not start
    wr(PSTE_IDX_TES, 8'h38);
    wr(PSTE_IDX_RUN_CTL, 8'h01);
    tick(3);
    rdc("blocked", PSTE_IDX_RUN_CTL, 8'h80, 8'h00);
    wr(PSTE_IDX_RUN_CTL, 8'h00);
    wr(PSTE_IDX_TES, 8'h00);
  endtask

  task automatic t_trig;
    wr(PSTE_IDX_TES, 8'h03);
    wr(PSTE_IDX_TRIG_MD, 8'h01);
    wr(PSTE_IDX_RUN_CTL, 8'h02);
    tick(2);
    port_a <= 3'h7;
    port_b <= 8'hFF;
    tick(4);
    rdc("prohib", PSTE_IDX_RUN_CTL, 8'h81, 8'h00);
    wr(PSTE_IDX_RUN_CTL, 8'h00);
    port_a <= 3'h0;
    port_b <= 8'h00;
    wr(PSTE_IDX_TES, 8'h0A);
    wr(PSTE_IDX_RUN_CTL, 8'h02);
    tick(2);
    port_b <= 8'h04;
    tick(1);
    port_b <= 8'h00;
    tick(3);
    rdc("glitch", PSTE_IDX_RUN_CTL, 8'h81, 8'h00);
    port_b <= 8'h04;
    tick(4);
    rdc("ext_start", PSTE_IDX_RUN_CTL, 8'h81, 8'h81);
    port_b <= 8'h00;
    wr(PSTE_IDX_RUN_CTL, 8'h00);
    tick(2);
    wr(PSTE_IDX_TRIG_MD, 8'h00);
    wr(PSTE_IDX_TES, 8'h00);
  endtask

  task automatic t_estop;
    int base;
    for (int k = 1; k < 4; k++) begin
      wr(PSTE_IDX_TES, 8'(k << 4));
      wr(PSTE_IDX_RUN_CTL, 8'h01);
      tick(3);
      base = irq_cnt;
      comparator_zero_out <= (k == 1);
      comparator_one_out <= (k == 2);
      port_b <= {7'h0, k == 3};
      repeat (5) @(posedge clk_i);
      chk("irq", 8'(base + 1), 8'(irq_cnt));
      chk_out(1'b0);
      rdc("estop", PSTE_IDX_RUN_CTL, 8'hE1, 8'h20);
      rdc("cnt_es", PSTE_IDX_CNT_LO, 8'hFF, 8'h00);
      wr(PSTE_IDX_RUN_CTL, 8'h00);
      rdc("w0_keep", PSTE_IDX_RUN_CTL, 8'h20, 8'h20);
      wr(PSTE_IDX_RUN_CTL, 8'h20);
      rdc("w1_clr", PSTE_IDX_RUN_CTL, 8'h20, 8'h00);
      {comparator_zero_out, comparator_one_out} <= 2'b00;
      port_b <= 8'h00;
      wr(PSTE_IDX_TES, 8'h00);
    end
  endtask

  // timer request as trigger: start, stop held off in delay, stop with clear
  task automatic t_ext;
    wr(PSTE_IDX_TES, 8'h05);
    wr(PSTE_IDX_TRIG_MD, 8'h07);
    wr(PSTE_IDX_WAIT, 8'h04);
    wr(PSTE_IDX_RUN_CTL, 8'h02);
    tmr <= 3'h1;
    tick(2);
    tmr <= 3'h0;
    tick(2);
    rdc("tmr_start", PSTE_IDX_RUN_CTL, 8'h81, 8'h01);
    tmr <= 3'h1;
    tick(2);
    rdc("delay_hold", PSTE_IDX_RUN_CTL, 8'h81, 8'h01);
    tmr <= 3'h0;
    tick(2);
    tmr <= 3'h1;
    tick(3);
    // cleared at the stop, then the one trailing count
    rdc("cnt_ext", PSTE_IDX_CNT_LO, 8'hFF, 8'h01);
    rdc("ext_stop", PSTE_IDX_RUN_CTL, 8'h81, 8'h00);
    wr(PSTE_IDX_RUN_CTL, 8'h00);
    tmr <= 3'h0;
    wr(PSTE_IDX_WAIT, 8'h00);
    wr(PSTE_IDX_TRIG_MD, 8'h00);
    wr(PSTE_IDX_TES, 8'h00);
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {error_cnt, n_tests} = '0;
    tmr = 3'h0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'b000;
    wb_adr = '0;
    wb_dat = '0;
    cnt_tick = 1'b0;
    port_a = 3'h0;
    port_b = 8'h00;
    {comparator_zero_out, comparator_one_out} = 2'b00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_walk;
    t_delay;
    t_trig;
    t_estop;
    t_ext;
    give_verdict;
  end
endmodule
